/* hdl/adcpm_dev.sv */
// converter end: frame decode, serial result shifter and power state control
`timescale 1ns/1ns
module adcpm_dev
  import adcpm_pkg::*;
#(
  parameter int unsigned POWERUP_CYCLES = adcpm_pkg::POWERUP_CYC
) (
  // clock and reset
  input  wire logic                           ref_clk,
  input  wire logic                           sys_rst,
  // serial link
  adcpm_link_if.dev                           link,
  // converter core side
  input  wire logic [adcpm_pkg::DATA_W-1:0]   sample_data,
  input  wire logic                           start_in_sleep,
  // status
  output logic                                analog_on,
  output logic                                fully_powered,
  output logic                                track_mode,
  output logic                                power_down,
  // result
  output logic [adcpm_pkg::DATA_W-1:0]        conv_result,
  output logic                                conv_valid,
  output logic                                conv_abort
);
  import adcpm_pkg::*;

  localparam int unsigned PW = $clog2(POWERUP_CYCLES + 1);

  logic                fs_s1_r;
  logic                fs_s2_r;
  logic                fs_d_r;
  logic                ck_s1_r;
  logic                ck_s2_r;
  logic                ck_d_r;
  logic                fs_fall;
  logic                fs_rise;
  logic                ck_fall;
  logic                ck_rise;
  logic                in_frame_r;
  logic                wake_r;
  logic                wake_nxt;
  logic                boot_r;
  logic                good_r;
  logic                first_edge_r;
  logic [CNT_W-1:0]    cnt_r;
  logic [WORD_W-1:0]   sh_r;
  logic [DATA_W-1:0]   held_r;
  logic [PW-1:0]       pwr_cnt_r;
  adcpm_pwr_e          pwr_r;
  adcpm_pwr_e          pwr_nxt;

  // two flops on both pins before any decode
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      fs_s1_r <= 1'h1;
      fs_s2_r <= 1'h1;
      fs_d_r  <= 1'h1;
      ck_s1_r <= 1'h1;
      ck_s2_r <= 1'h1;
      ck_d_r  <= 1'h1;
    end else begin
      fs_s1_r <= link.frame_sel_n;
      fs_s2_r <= fs_s1_r;
      fs_d_r  <= fs_s2_r;
      ck_s1_r <= link.sclk;
      ck_s2_r <= ck_s1_r;
      ck_d_r  <= ck_s2_r;
    end
  end

  assign fs_fall = fs_d_r & ~fs_s2_r;
  assign fs_rise = ~fs_d_r & fs_s2_r;
  // clock edges count only inside a frame
  assign ck_fall = ck_d_r & ~ck_s2_r & in_frame_r & ~fs_s2_r;
  assign ck_rise = ~ck_d_r & ck_s2_r & in_frame_r & ~fs_s2_r;

  // frame tracking and falling edge count
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      in_frame_r <= 1'h0;
      cnt_r      <= 5'h00;
    end else if (fs_fall) begin
      in_frame_r <= 1'h1;
      cnt_r      <= 5'h00;
    end else if (fs_rise) begin
      in_frame_r <= 1'h0;
    end else if (ck_fall && cnt_r < EDGE_LAST) begin
      cnt_r      <= cnt_r + 5'h01;
    end
  end

  // next power state, decided only when a started frame ends
  always_comb begin
    pwr_nxt  = pwr_r;
    wake_nxt = wake_r;
    if (fs_fall) begin
      wake_nxt = (pwr_r == PWR_DOWN);
    end else if (fs_rise && in_frame_r) begin
      wake_nxt = 1'h0;
      if (wake_r) begin
        pwr_nxt = (cnt_r < EDGE_AWAKE) ? PWR_DOWN : PWR_NORMAL;
      end else if (cnt_r >= EDGE_PD_MIN && cnt_r < EDGE_AWAKE) begin
        pwr_nxt = PWR_DOWN;
      end else begin
        pwr_nxt = PWR_NORMAL;
      end
    end
  end

  // start mode is caught from the strap one edge after reset release
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      boot_r <= 1'h1;
      pwr_r  <= PWR_NORMAL;
      wake_r <= 1'h0;
    end else if (boot_r) begin
      boot_r <= 1'h0;
      pwr_r  <= start_in_sleep ? PWR_DOWN : PWR_NORMAL;
    end else begin
      pwr_r  <= pwr_nxt;
      wake_r <= wake_nxt;
    end
  end

  // analog supply: on in normal mode and for the length of a wake frame
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      analog_on  <= 1'h0;
      power_down <= 1'h0;
    end else if (boot_r) begin
      analog_on  <= ~start_in_sleep;
      power_down <= start_in_sleep;
    end else begin
      analog_on  <= (pwr_nxt == PWR_NORMAL) | wake_nxt;
      power_down <= (pwr_nxt == PWR_DOWN);
    end
  end

  // power-up timer restarts whenever the analog side is switched off
  always_ff @(posedge ref_clk) begin
    if (sys_rst || !analog_on) begin
      pwr_cnt_r     <= '0;
      fully_powered <= 1'h0;
    end else if (pwr_cnt_r == PW'(POWERUP_CYCLES)) begin
      fully_powered <= 1'h1;
    end else begin
      pwr_cnt_r     <= pwr_cnt_r + PW'(1);
    end
  end

  // sampling stage: track at start, hold from select fall
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      track_mode   <= 1'h1;
      first_edge_r <= 1'h0;
    end else if (fs_fall) begin
      track_mode   <= 1'h0;
      first_edge_r <= (pwr_r == PWR_DOWN);
    end else if (fs_rise && in_frame_r) begin
      track_mode   <= (pwr_nxt == PWR_NORMAL);
      first_edge_r <= 1'h0;
    end else if (first_edge_r && (ck_fall || ck_rise)) begin
      track_mode   <= 1'h1;
      first_edge_r <= 1'h0;
    end else if (ck_rise && cnt_r >= EDGE_TRACK) begin
      track_mode   <= 1'h1;
    end
  end

  // result shifter: zero at select fall, one bit per clock fall up to the fifteenth, output released at the sixteenth
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      link.serial_out    <= 1'h0;
      link.serial_out_oe <= 1'h0;
      sh_r               <= '0;
      held_r             <= '0;
    end else if (fs_fall) begin
      link.serial_out    <= 1'h0;
      link.serial_out_oe <= 1'h1;
      sh_r               <= {{(WORD_W-DATA_W-1){1'h0}}, sample_data, 1'h0};
      held_r             <= sample_data;
    end else if (fs_rise) begin
      link.serial_out    <= 1'h0;
      link.serial_out_oe <= 1'h0;
    end else if (ck_fall && cnt_r < EDGE_LAST) begin
      if (cnt_r == EDGE_LAST - 5'h01) begin
        link.serial_out    <= 1'h0;
        link.serial_out_oe <= 1'h0;
      end else begin
        link.serial_out    <= sh_r[WORD_W-1];
        sh_r               <= {sh_r[WORD_W-2:0], 1'h0};
      end
    end
  end

  // only frames begun fully powered and not waking give valid data
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      good_r      <= 1'h0;
      conv_valid  <= 1'h0;
      conv_abort  <= 1'h0;
      conv_result <= '0;
    end else begin
      conv_valid <= 1'h0;
      conv_abort <= 1'h0;
      if (fs_fall) begin
        good_r <= (pwr_r == PWR_NORMAL) & fully_powered;
      end else if (fs_rise && in_frame_r && cnt_r < EDGE_LAST) begin
        conv_abort <= 1'h1;
      end else if (ck_fall && cnt_r == EDGE_LAST - 5'h01 && good_r) begin
        conv_valid  <= 1'h1;
        conv_result <= held_r;
      end
    end
  end

endmodule : adcpm_dev

/* inc/adcpm_pkg.sv */
// shared constants and types for the converter mode and power control link
package adcpm_pkg;

  // word layout: leading zeros then the conversion result
  localparam int unsigned DATA_W        = 12;
  localparam int unsigned WORD_W        = 16;
  localparam int unsigned CNT_W         = 5;

  // serial clock falling edge counts within one frame
  localparam logic [4:0]  EDGE_PD_MIN   = 5'h02;
  localparam logic [4:0]  EDGE_AWAKE    = 5'h0A;
  localparam logic [4:0]  EDGE_TRACK    = 5'h0D;
  localparam logic [4:0]  EDGE_LAST     = 5'h10;
  localparam logic [4:0]  EDGE_SLEEP    = 5'h08;

  // timing on the 125 MHz reference clock
  localparam int unsigned CLK_NS        = 8;
  localparam int unsigned POWERUP_NS    = 1000;
  localparam int unsigned POWERUP_CYC   = POWERUP_NS / CLK_NS;
  localparam int unsigned QUIET_NS      = 100;
  localparam int unsigned QUIET_CYC     = (QUIET_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned SCLK_HALF_CYC = 10;
  localparam int unsigned SYNC_LAG_CYC  = 4;

  typedef enum logic {
    PWR_NORMAL,
    PWR_DOWN
  } adcpm_pwr_e;

  typedef enum logic [1:0] {
    FRAME_CONVERT,
    FRAME_SLEEP,
    FRAME_WAKE
  } adcpm_frame_e;

  typedef enum logic [2:0] {
    HST_IDLE,
    HST_LEAD,
    HST_CLOCK,
    HST_TAIL,
    HST_QUIET
  } adcpm_hst_e;

endpackage : adcpm_pkg

/* inc/adcpm_link_if.sv */
// serial link between the host port and the converter control
`timescale 1ns/1ns
interface adcpm_link_if;
  logic frame_sel_n;
  logic sclk;
  logic serial_out;
  logic serial_out_oe;

  modport dev (
    input  frame_sel_n,
    input  sclk,
    output serial_out,
    output serial_out_oe
  );

  modport host (
    output frame_sel_n,
    output sclk,
    input  serial_out,
    input  serial_out_oe
  );
endinterface : adcpm_link_if

/* hdl/adcpm_host.sv */
// host end: frame generator with serial clock divider and result capture
`timescale 1ns/1ns
module adcpm_host
  import adcpm_pkg::*;
#(
  parameter int unsigned SCLK_HALF = adcpm_pkg::SCLK_HALF_CYC,
  parameter int unsigned QUIET_WAIT = adcpm_pkg::QUIET_CYC + adcpm_pkg::SYNC_LAG_CYC
) (
  // clock and reset
  input  wire logic                           ref_clk,
  input  wire logic                           sys_rst,
  // serial link
  adcpm_link_if.host                          link,
  // command side
  input  wire logic                           cmd_valid,
  input  wire adcpm_pkg::adcpm_frame_e        cmd_kind,
  output logic                                cmd_ready,
  // result side
  output logic [adcpm_pkg::DATA_W-1:0]        result,
  output logic                                result_valid
);
  import adcpm_pkg::*;

  localparam int unsigned DW = $clog2(SCLK_HALF + 1);
  localparam int unsigned QW = $clog2(QUIET_WAIT + 1);

  adcpm_hst_e          st_r;
  adcpm_frame_e        kind_r;
  logic [DW-1:0]       div_r;
  logic                tick_r;
  logic [QW-1:0]       qcnt_r;
  logic [CNT_W-1:0]    falls_r;
  logic [CNT_W-1:0]    need;
  logic [WORD_W-1:0]   rx_r;
  logic                so_s1_r;
  logic                so_s2_r;
  logic                oe_s1_r;
  logic                oe_s2_r;
  logic                so_seen;

  // a sleep frame stops inside the power-down window
  assign need = (kind_r == FRAME_SLEEP) ? EDGE_SLEEP : EDGE_LAST;

  // data pin comes from the other end, two flops on each line before any gating
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      so_s1_r <= 1'h0;
      so_s2_r <= 1'h0;
      oe_s1_r <= 1'h0;
      oe_s2_r <= 1'h0;
    end else begin
      so_s1_r <= link.serial_out;
      so_s2_r <= so_s1_r;
      oe_s1_r <= link.serial_out_oe;
      oe_s2_r <= oe_s1_r;
    end
  end

  // a released line reads as low
  assign so_seen = so_s2_r & oe_s2_r;

  // half-period enable for the serial clock
  always_ff @(posedge ref_clk) begin
    if (sys_rst || st_r == HST_IDLE) begin
      div_r  <= '0;
      tick_r <= 1'h0;
    end else if (div_r == DW'(SCLK_HALF - 1)) begin
      div_r  <= '0;
      tick_r <= 1'h1;
    end else begin
      div_r  <= div_r + DW'(1);
      tick_r <= 1'h0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_r             <= HST_IDLE;
      kind_r           <= FRAME_CONVERT;
      link.frame_sel_n <= 1'h1;
      link.sclk        <= 1'h1;
      cmd_ready        <= 1'h1;
      falls_r          <= 5'h00;
      qcnt_r           <= '0;
      rx_r             <= '0;
      result           <= '0;
      result_valid     <= 1'h0;
    end else begin
      result_valid <= 1'h0;
      unique case (st_r)
        HST_IDLE: begin
          // select idles high between frames
          if (cmd_valid && cmd_ready) begin
            kind_r           <= cmd_kind;
            link.frame_sel_n <= 1'h0;
            cmd_ready        <= 1'h0;
            falls_r          <= 5'h00;
            st_r             <= HST_LEAD;
          end
        end
        HST_LEAD: begin
          if (tick_r) begin
            link.sclk <= 1'h0;
            falls_r   <= 5'h01;
            st_r      <= HST_CLOCK;
          end
        end
        HST_CLOCK: begin
          if (tick_r) begin
            if (!link.sclk) begin
              link.sclk <= 1'h1;
              if (falls_r < EDGE_LAST) begin
                rx_r <= {rx_r[WORD_W-2:0], so_seen};
              end
              if (falls_r == need) begin
                st_r <= HST_TAIL;
              end
            end else begin
              link.sclk <= 1'h0;
              falls_r   <= falls_r + 5'h01;
            end
          end
        end
        HST_TAIL: begin
          // a full wake frame at this clock exceeds the power-up time
          if (tick_r) begin
            link.frame_sel_n <= 1'h1;
            qcnt_r           <= '0;
            st_r             <= HST_QUIET;
            if (kind_r == FRAME_CONVERT) begin
              result       <= rx_r[DATA_W-1:0];
              result_valid <= 1'h1;
            end
          end
        end
        HST_QUIET: begin
          // margin covers the far end's input synchroniser
          if (qcnt_r == QW'(QUIET_WAIT - 1)) begin
            cmd_ready <= 1'h1;
            st_r      <= HST_IDLE;
          end else begin
            qcnt_r <= qcnt_r + QW'(1);
          end
        end
      endcase
    end
  end

endmodule : adcpm_host

/* tb/adcpm_link_props.sv */
// concurrent checks on the serial link between host and converter ends
`timescale 1ns/1ns
module adcpm_link_props #(
  parameter int QUIET_MIN = 13
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // serial link
  input wire logic frame_sel_n,
  input wire logic sclk,
  input wire logic serial_out,
  input wire logic serial_out_oe
);
  logic [7:0] hi_cnt_r;
  logic [4:0] fall_cnt_r;
  logic       sclk_d_r;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  // saturates so a long idle never wraps into a short gap
  always_ff @(posedge ref_clk) begin
    if (sys_rst) hi_cnt_r <= 8'hFF;
    else if (!frame_sel_n) hi_cnt_r <= 8'h00;
    else if (hi_cnt_r != 8'hFF) hi_cnt_r <= hi_cnt_r + 8'h01;
  end

  always_ff @(posedge ref_clk) begin
    sclk_d_r <= sclk;
  end

  // counted at the pins, ahead of the device's own synchronised view
  always_ff @(posedge ref_clk) begin
    if (sys_rst || frame_sel_n) fall_cnt_r <= 5'h00;
    else if (sclk_d_r && !sclk) fall_cnt_r <= fall_cnt_r + 5'h01;
  end

  sequence lead_zeros_s;
    (!serial_out) [*8];
  endsequence

  oe_release_a: assert property (frame_sel_n [*5] |-> !serial_out_oe)
    else $error("output still driven after select rise");
  oe_start_a: assert property ($fell(frame_sel_n) |-> ##[1:5] serial_out_oe)
    else $error("output not driven after select fall");
  lead_zero_a: assert property ($rose(serial_out_oe) |-> lead_zeros_s)
    else $error("leading bit not zero");
  sclk_idle_a: assert property (frame_sel_n |-> sclk)
    else $error("serial clock low outside frame");
  quiet_gap_a: assert property ($fell(frame_sel_n) |-> hi_cnt_r >= QUIET_MIN)
    else $error("quiet time too short");
  fall_limit_a: assert property (!frame_sel_n |-> fall_cnt_r <= 5'h10)
    else $error("more than sixteen clock falls");
  release_16_a: assert property (fall_cnt_r == 5'h10 |-> ##[0:4] !serial_out_oe)
    else $error("output not released after last fall");
  oe_hold_a: assert property (!frame_sel_n && fall_cnt_r inside {[5'h01:5'h0F]} |-> serial_out_oe)
    else $error("output dropped inside frame");
endmodule : adcpm_link_props

/* tb/adcpm_tb.sv */
// bench: host and converter back to back, plus a bench-driven converter end
`timescale 1ns/1ns
module adcpm_tb;
  import adcpm_pkg::*;
  localparam int PU_CYC = 40;
  logic         ref_clk;
  logic         sys_rst;
  logic [11:0]  sample_data;
  logic         cmd_valid;
  adcpm_frame_e cmd_kind;
  logic         cmd_ready;
  logic [11:0]  result;
  logic [11:0]  conv_result;
  logic         result_valid;
  logic         analog_on, fully_powered, track_mode, power_down, conv_valid;
  logic         analog_on_b, power_down_b, conv_abort_b, abort_b;
  logic         rv_seen, cv_seen, trk40;
  int           n_fail;
  int           check_count;

  adcpm_link_if link_a ();
  adcpm_link_if link_b ();

  adcpm_dev #(.POWERUP_CYCLES(PU_CYC)) adcpm_dev_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .link(link_a),
    .sample_data(sample_data), .start_in_sleep(1'b0), .analog_on(analog_on), .fully_powered(fully_powered),
    .track_mode(track_mode), .power_down(power_down), .conv_result(conv_result), .conv_valid(conv_valid),
    .conv_abort());
  adcpm_host adcpm_host_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .link(link_a), .cmd_valid(cmd_valid),
    .cmd_kind(cmd_kind), .cmd_ready(cmd_ready), .result(result), .result_valid(result_valid));
  // second converter end, framed by the bench so it can break the host's habits
  adcpm_dev #(.POWERUP_CYCLES(PU_CYC)) adcpm_dev_fault_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .link(link_b), .sample_data(12'h000), .start_in_sleep(1'b1), .analog_on(analog_on_b),
    .fully_powered(), .track_mode(), .power_down(power_down_b), .conv_result(), .conv_valid(),
    .conv_abort(conv_abort_b));
  adcpm_link_props #(.QUIET_MIN(QUIET_CYC)) adcpm_link_props_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .frame_sel_n(link_a.frame_sel_n), .sclk(link_a.sclk), .serial_out(link_a.serial_out),
    .serial_out_oe(link_a.serial_out_oe));

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    if (conv_abort_b === 1'b1) abort_b <= 1'b1;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc

  task automatic check_bit(input logic got, input logic exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask : check_bit

  task automatic check_word(input logic [11:0] got, input logic [11:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check_word

  task automatic host_cmd(input adcpm_frame_e kind);
    rv_seen = 1'b0;
    cv_seen = 1'b0;
    check_bit(cmd_ready, 1'b1, "ready before command");
    cmd_kind = kind;
    cmd_valid = 1'b1;
    cyc(1);
    cmd_valid = 1'b0;
    // bounded wait for the host to finish frame and quiet time
    for (int i = 0; i < 800 && cmd_ready !== 1'b1; i++) begin
      if (result_valid === 1'b1) rv_seen = 1'b1;
      if (conv_valid === 1'b1) cv_seen = 1'b1;
      if (i == 40) trk40 = track_mode;
      cyc(1);
    end
    check_bit(cmd_ready, 1'b1, "host back to idle");
  endtask : host_cmd

  task automatic frame_b(input int n);
    abort_b = 1'b0;
    link_b.frame_sel_n = 1'b0;
    cyc(10);
    repeat (n) begin
      link_b.sclk = 1'b0;
      cyc(10);
      link_b.sclk = 1'b1;
      cyc(10);
    end
    link_b.frame_sel_n = 1'b1;
    cyc(20);
  endtask : frame_b

  task automatic t_start;
    check_bit(track_mode, 1'b1, "tracking at start");
    check_bit(power_down, 1'b0, "strap normal");
    check_bit(power_down_b, 1'b1, "strap sleep");
  endtask : t_start

  task automatic t_convert(input logic [11:0] val);
    sample_data = val;
    host_cmd(FRAME_CONVERT);
    check_word(result, val, "host result");
    check_word(conv_result, val, "device result");
    check_bit(rv_seen, 1'b1, "result pulse");
    check_bit(cv_seen, 1'b1, "valid pulse");
    check_bit(trk40, 1'b0, "hold during convert");
    check_bit(power_down, 1'b0, "still normal");
  endtask : t_convert

  task automatic t_sleep_wake;
    host_cmd(FRAME_SLEEP);
    check_bit(power_down, 1'b1, "asleep after short burst");
    check_bit(analog_on, 1'b0, "analog off");
    check_bit(rv_seen, 1'b0, "no result on sleep");
    host_cmd(FRAME_WAKE);
    check_bit(trk40, 1'b1, "tracking early in wake");
    check_bit(power_down, 1'b0, "awake after dummy");
    check_bit(cv_seen, 1'b0, "dummy not valid");
    check_bit(fully_powered, 1'b1, "fully powered");
    t_convert(12'h3C7);
  endtask : t_sleep_wake

  task automatic t_fault;
    frame_b(12);
    check_bit(power_down_b, 1'b0, "woken by long frame");
    frame_b(1);
    check_bit(power_down_b, 1'b0, "glitch keeps normal");
    frame_b(12);
    check_bit(abort_b, 1'b1, "abort between 10 and 16");
    check_bit(power_down_b, 1'b0, "abort stays powered");
    check_bit(link_b.serial_out_oe, 1'b0, "output released");
    frame_b(5);
    check_bit(power_down_b, 1'b1, "rise after fall 5 sleeps");
    frame_b(9);
    check_bit(power_down_b, 1'b1, "early rise back to sleep");
    check_bit(analog_on_b, 1'b0, "analog off again");
  endtask : t_fault

  task automatic finish_test;
    if (n_fail == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test

  initial begin
    cyc(20000);
    n_fail++;
    finish_test;
  end

  initial begin
    n_fail = 0;
    check_count = 0;
    sys_rst = 1'b1;
    sample_data = 12'h000;
    cmd_valid = 1'b0;
    cmd_kind = FRAME_CONVERT;
    abort_b = 1'b0;
    trk40 = 1'b0;
    link_b.frame_sel_n = 1'b1;
    link_b.sclk = 1'b1;
    cyc(4);
    sys_rst = 1'b0;
    cyc(3);
    t_start;
    cyc(PU_CYC + 5);
    t_convert(12'hA5C);
    t_sleep_wake;
    t_fault;
    finish_test;
  end
endmodule : adcpm_tb
